// *** dv/pcfg_host.sv ***
// Host model issuing configuration read and write cycles
module pcfg_host (
  input wire logic ref_clk,
  output pcfg_pkg::pcfg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic cfg_cycle(input logic wr, input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(negedge ref_clk);
    req = '{valid: 1'b1, write: wr, addr: a, byte_en: be, wdata: wd};
    @(negedge ref_clk);
    rd = rdata;
    ok = rvalid;
    // Released fields flip so stale values never pass for live ones
    req = '{valid: 1'b0, write: ~wr, addr: ~a, byte_en: ~be, wdata: ~wd};
  endtask
endmodule

// *** dv/pcfg_regs_props.sv ***
// Concurrent checks on the configuration register bank ports
module pcfg_regs_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic eeprom_valid,
  input wire pcfg_pkg::pcfg_eeprom_t eeprom_data,
  input wire pcfg_pkg::pcfg_req_t req,
  input wire pcfg_pkg::pcfg_event_t events,
  input wire logic capability_offered,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic serr_assert,
  input wire logic system_error_status,
  input wire pcfg_pkg::pcfg_ctrl_t ctrl
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // --------------------------------
  // Sequences
  // --------------------------------
  sequence s_read;
    req.valid && !req.write;
  endsequence
  sequence s_read_at(logic [7:0] a);
    req.valid && !req.write && req.addr == a && req.byte_en == 4'hF;
  endsequence

  // --------------------------------
  // Properties
  // --------------------------------
  property p_read_answer;
    s_read |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read without answer");
  property p_quiet_bus;
    !(req.valid && !req.write) |=> !rvalid;
  endproperty
  a_quiet_bus: assert property (p_quiet_bus) else $error("answer without read");
  property p_fixed_status;
    s_read_at(pcfg_pkg::OFF_COMMAND_STATUS) |=>
      rdata[26:25] == pcfg_pkg::SELECT_TIMING_MEDIUM && rdata[23];
  endproperty
  a_fixed_status: assert property (p_fixed_status) else $error("fixed status bits");
  property p_signature;
    s_read_at(pcfg_pkg::OFF_SIGNATURE) |=> rdata == pcfg_pkg::SIGNATURE_VALUE;
  endproperty
  a_signature: assert property (p_signature) else $error("signature value");
  property p_reserved;
    s_read_at(8'h18) |=> rdata == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved offset not zero");
  // Enables lag the command word by one cycle, so next-cycle ctrl shows the enable at the event
  property p_serr_cause;
    events.address_parity_error |=> serr_assert == ctrl.system_error_response_enable;
  endproperty
  a_serr_cause: assert property (p_serr_cause) else $error("system error not driven");
  property p_serr_only;
    !events.address_parity_error |=> !serr_assert;
  endproperty
  a_serr_only: assert property (p_serr_only) else $error("system error without cause");
  property p_sys_err;
    (events.parity_error || events.address_parity_error)
      |=> system_error_status == ctrl.parity_response_enable;
  endproperty
  a_sys_err: assert property (p_sys_err) else $error("error status not raised");
  property p_sys_err_only;
    !(events.parity_error || events.address_parity_error) |=> !system_error_status;
  endproperty
  a_sys_err_only: assert property (p_sys_err_only) else $error("error status unprompted");
  property p_reset_ctrl;
    $rose(reset_n) |-> ctrl == '0;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("enables set after reset");
endmodule

// *** dv/pci_config_register_space_tb.sv ***
// Self-checking bench for the configuration register bank
module pci_config_register_space_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] exp;
  } pcfg_row_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  logic eeprom_valid = 1'b0;
  pcfg_pkg::pcfg_eeprom_t eeprom_data =
    {16'hD00D, 16'h1A2B, 16'h5566, 16'h7788, 32'hCAFE0123, 8'h40, 8'h0A};
  pcfg_pkg::pcfg_req_t req;
  pcfg_pkg::pcfg_event_t events = '0;
  logic capability_offered = 1'b1;
  logic [31:0] rdata;
  logic rvalid;
  logic serr_assert;
  logic system_error_status;
  pcfg_pkg::pcfg_ctrl_t ctrl;
  int mismatches = 0;
  int n_checks = 0;
  // Each row: write, then full read-back
  pcfg_row_t rows [19] = '{
    '{8'h00, 4'hF, 32'h12345678, 32'hD00D1A2B},
    '{8'h04, 4'hF, 32'hFFFFFFFF, 32'h02900147},
    '{8'h08, 4'hF, 32'hFFFFFFFF, pcfg_pkg::CLASS_REVISION_VALUE},
    '{8'h0C, 4'hF, 32'hFFFFFFFF, 32'h0000FFFF},
    '{8'h10, 4'hF, 32'hFFFFFFFF, 32'hFFFFFF01},
    '{8'h14, 4'hF, 32'hFFFFFFFF, 32'hFFFFFC00},
    '{8'h18, 4'hF, 32'hFFFFFFFF, 32'h00000000},
    '{8'h28, 4'hF, 32'h00000000, 32'hCAFE0123},
    '{8'h2C, 4'hF, 32'h00000000, 32'h55667788},
    '{8'h30, 4'hF, 32'hFFFFFFFF, 32'hFFFE0001},
    '{8'h34, 4'hF, 32'hFFFFFFFF, 32'h000000C0},
    '{8'h3C, 4'hF, 32'hFFFFFFFF, 32'h400A01FF},
    '{8'h40, 4'hF, 32'hFFFFFFFF, 32'h0000FF00},
    '{8'h40, 4'h2, 32'h00000000, 32'h00000000},
    '{8'h40, 4'h1, 32'hFFFFFFFF, 32'h00000000},
    '{8'h40, 4'h2, 32'h0000AB00, 32'h0000AB00},
    '{8'h80, 4'hF, 32'h00000000, pcfg_pkg::SIGNATURE_VALUE},
    '{8'hC0, 4'hF, 32'h00000000, pcfg_pkg::POWER_CAP_VALUE},
    '{8'hC4, 4'hF, 32'hFFFFFFFF, 32'h00001F00}};

  always #4 ref_clk = ~ref_clk;

  pcfg_regs pcfg_regs_inst (.ref_clk(ref_clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .eeprom_valid(eeprom_valid), .eeprom_data(eeprom_data), .req(req), .events(events),
    .capability_offered(capability_offered), .rdata(rdata), .rvalid(rvalid),
    .serr_assert(serr_assert), .system_error_status(system_error_status), .ctrl(ctrl));
  pcfg_host pcfg_host_inst (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic ok;
    pcfg_host_inst.cfg_cycle(1'b1, a, be, wd, d, ok);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    pcfg_host_inst.cfg_cycle(1'b0, a, be, 32'h0, d, ok);
    check32("rvalid", 32'h1, {31'h0, ok});
    check32($sformatf("offset %h", a), exp, d);
  endtask
  task automatic pulse(input pcfg_pkg::pcfg_event_t e);
    @(negedge ref_clk);
    events = e;
    @(negedge ref_clk);
    events = '0;
  endtask
  task automatic hw_reset();
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
  endtask
  task automatic load_eeprom();
    @(negedge ref_clk);
    eeprom_valid = 1'b1;
    @(negedge ref_clk);
    eeprom_valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------
  // Sequence of tests
  // --------------------------------
  initial
  begin
    hw_reset();
    load_eeprom();
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].be, rows[i].wd);
      rd_chk(rows[i].addr, 4'hF, rows[i].exp);
    end
    rd_chk(8'h04, 4'h8, 32'h02000000);
    check32("ctrl", 32'h3F, {26'h0, ctrl});
    pulse(7'h7E);
    rd_chk(8'h04, 4'hF, 32'hF3900147);
    pulse(7'h01);
    rd_chk(8'hC4, 4'hF, 32'h00009F00);
    wr(8'h04, 4'h8, 32'h00000000);
    rd_chk(8'h04, 4'hF, 32'hF3900147);
    wr(8'h04, 4'h8, 32'hF1000000);
    rd_chk(8'h04, 4'hF, 32'h02900147);
    // Involvement without mastering must not report
    pulse(7'h04);
    rd_chk(8'h04, 4'hF, 32'h02900147);
    pulse(7'h10);
    rd_chk(8'h04, 4'hF, 32'h22900147);
    pulse(7'h08);
    rd_chk(8'h04, 4'hF, 32'h32900147);
    wr(8'h04, 4'hF, 32'h20000147);
    rd_chk(8'h04, 4'hF, 32'h12900147);
    wr(8'h04, 4'h8, 32'h10000000);
    wr(8'h04, 4'h3, 32'h00000000);
    pulse(7'h40);
    rd_chk(8'h04, 4'hF, 32'h82900000);
    check32("ctrl", 32'h00, {26'h0, ctrl});
    @(negedge ref_clk);
    soft_reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    soft_reset = 1'b0;
    rd_chk(8'h40, 4'hF, 32'h0000AB00);
    rd_chk(8'h10, 4'hF, 32'hFFFFFF01);
    capability_offered = 1'b0;
    hw_reset();
    rd_chk(8'h00, 4'hF, 32'h00000000);
    rd_chk(8'h04, 4'hF, 32'h02800000);
    rd_chk(8'h40, 4'hF, 32'h00000000);
    check32("ctrl", 32'h00, {26'h0, ctrl});
    load_eeprom();
    rd_chk(8'h00, 4'hF, 32'hD00D1A2B);
    tally_and_finish();
  end

  // Tests need well under 2000 cycles
  initial
  begin
    #200us;
    mismatches++;
    tally_and_finish();
  end
endmodule

bind pcfg_regs pcfg_regs_props pcfg_regs_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .soft_reset(soft_reset), .eeprom_valid(eeprom_valid), .eeprom_data(eeprom_data),
  .req(req), .events(events), .capability_offered(capability_offered), .rdata(rdata),
  .rvalid(rvalid), .serr_assert(serr_assert), .system_error_status(system_error_status),
  .ctrl(ctrl));

// *** verilog/pcfg_pkg.sv ***
// Package: offsets, field positions, reset values and carriers for the config register bank
package pcfg_pkg;

  // Word offsets (byte addresses, low two bits ignored)
  localparam logic [7:0] OFF_LOADED_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_COMMAND_STATUS = 8'h04;
  localparam logic [7:0] OFF_CLASS_REVISION = 8'h08;
  localparam logic [7:0] OFF_LATENCY_LINE = 8'h0C;
  localparam logic [7:0] OFF_IO_BASE = 8'h10;
  localparam logic [7:0] OFF_MEMORY_BASE = 8'h14;
  localparam logic [7:0] OFF_CARD_INFO = 8'h28;
  localparam logic [7:0] OFF_SUBSYSTEM_ID = 8'h2C;
  localparam logic [7:0] OFF_BOOT_ROM_BASE = 8'h30;
  localparam logic [7:0] OFF_CAPABILITY_PTR = 8'h34;
  localparam logic [7:0] OFF_INTERRUPT_TIMING = 8'h3C;
  localparam logic [7:0] OFF_DRIVER_SCRATCH = 8'h40;
  localparam logic [7:0] OFF_SIGNATURE = 8'h80;
  localparam logic [7:0] OFF_POWER_CAP = 8'hC0;
  localparam logic [7:0] OFF_POWER_CTRL = 8'hC4;

  // Command/status field positions
  localparam int BIT_PARITY_ERROR_SEEN = 31;
  localparam int BIT_SYSTEM_ERROR_SIGNALLED = 30;
  localparam int BIT_MASTER_ABORT_SEEN = 29;
  localparam int BIT_TARGET_ABORT_SEEN = 28;
  localparam int BIT_SELECT_TIMING_HI = 26;
  localparam int BIT_SELECT_TIMING_LO = 25;
  localparam int BIT_DATA_PARITY_REPORTED = 24;
  localparam int BIT_BACK_TO_BACK_CAPABLE = 23;
  localparam int BIT_NEW_CAPABILITIES = 20;
  localparam int BIT_SYSTEM_ERROR_RESPONSE = 8;
  localparam int BIT_PARITY_RESPONSE = 6;
  localparam int BIT_BUS_MASTER = 2;
  localparam int BIT_MEMORY_SPACE = 1;
  localparam int BIT_IO_SPACE = 0;

  localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
  localparam logic [31:0] STATUS_CLEAR_MASK = 32'hF1000000;

  // Fixed values
  localparam logic [31:0] CLASS_REVISION_VALUE = 32'h02000011;
  localparam logic [7:0] CAPABILITY_PTR_VALUE = 8'hC0;
  localparam logic [7:0] INTERRUPT_PIN_VALUE = 8'h01;
  localparam logic [31:0] POWER_CAP_VALUE = 32'hFE020001;
  // Arbitrary neutral signature, not any real maker's code
  localparam logic [31:0] SIGNATURE_VALUE = 32'h5A5A0001;
  localparam logic [31:0] IO_BASE_RESET = 32'h00000001;
  localparam logic [31:0] IO_BASE_MASK = 32'hFFFFFF00;
  localparam logic [31:0] MEMORY_BASE_MASK = 32'hFFFFFC00;
  localparam logic [31:0] BOOT_ROM_MASK = 32'hFFFE0001;
  localparam logic [31:0] SCRATCH_MASK = 32'h0000FF00;
  localparam logic [31:0] POWER_CTRL_RW_MASK = 32'h00001F00;
  localparam int BIT_PME_STATUS = 15;

  // Identification values recalled from the serial memory
  typedef struct packed {
    logic [15:0] loaded_device_code;
    logic [15:0] loaded_maker_code;
    logic [15:0] subsystem_device;
    logic [15:0] subsystem_maker;
    logic [31:0] card_info;
    logic [7:0] max_latency;
    logic [7:0] min_grant;
  } pcfg_eeprom_t;

  // Configuration access from the target engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } pcfg_req_t;

  // Error and power-management events from the bus engine, one-cycle pulses
  typedef struct packed {
    logic parity_error;
    logic address_parity_error;
    logic master_abort;
    logic target_abort;
    logic perr_involved;
    logic acting_master;
    logic pme_event;
  } pcfg_event_t;

  // Control bits for the rest of the controller
  typedef struct packed {
    logic bus_master_enable;
    logic memory_space_enable;
    logic io_space_enable;
    logic parity_response_enable;
    logic system_error_response_enable;
    logic boot_rom_enable;
  } pcfg_ctrl_t;

endpackage

// *** verilog/pcfg_regs.sv ***
// Configuration register bank reached by configuration read and write cycles
//
// Overview of operation
// - Hardware reset returns every configuration register to its default.
// - Software reset leaves all configuration registers untouched.
// - Byte, word and double-word accesses honour their byte enables.
// - Identifiers, card info, subsystem, latency and grant reload from serial memory.
// - Card-information register is read-only; writes ignored.
// - Driver space keeps only bits 15-8 writable; survives software reset.
// - Signature register is a hard-wired read-only constant.
// - Loaded identity shows device code high, maker code low, read-only.
// - Bit 31 sets on any detected parity error.
// - Bit 30 sets when the system error output is driven; resets 0.
// - Bit 29 sets on master abort of own transaction.
// - Bit 28 sets on received target abort as master.
// - Bits 26:25 read constant 01, medium select timing.
// - Bit 24 sets only with PERR involvement, mastering, parity response enabled.
// - Bit 23 always reads 1.
// - Bit 20 is read-only, mirrors control/status register 18 bit 19.
// - Bit 8 set makes address parity errors assert the system error output.
// - Bit 6 clear ignores parity errors; set raises system error status.
// - Bit 2 gates all bus-master activity; resets 0.
// - Bit 1 enables memory-space response; resets 0.
// - Bit 0 enables I/O-space response; resets 0.
module pcfg_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic eeprom_valid,
  input wire pcfg_pkg::pcfg_eeprom_t eeprom_data,
  input wire pcfg_pkg::pcfg_req_t req,
  input wire pcfg_pkg::pcfg_event_t events,
  input wire logic capability_offered,
  output logic [31:0] rdata,
  output logic rvalid,
  output logic serr_assert,
  output logic system_error_status,
  output pcfg_pkg::pcfg_ctrl_t ctrl
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Byte enables widened to one mask bit per data bit
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge write data into a register under byte enables and a field mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] rw);
    logic [31:0] m;
    m = lane_mask(be) & rw;
    merge = (old & ~m) | (wd & m);
  endfunction

  // Word match only; the byte offset bits play no part
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic wr;
  logic [31:0] be_mask;
  pcfg_pkg::pcfg_eeprom_t ident_q;
  logic [31:0] command_q;
  logic [31:0] status_q;
  logic [7:0] latency_q;
  logic [7:0] line_size_q;
  logic [31:0] io_base_q;
  logic [31:0] memory_base_q;
  logic [31:0] boot_rom_q;
  logic [7:0] int_line_q;
  logic [31:0] scratch_q;
  logic [31:0] power_ctrl_q;
  logic cap_sync1_q;
  logic cap_sync2_q;
  logic [31:0] rdata_d;
  logic [31:0] stat_wr_clear;
  logic system_error_d;
  logic wr_cmd;
  logic wr_power;
  logic pme_clear;
  logic [31:0] power_merged;

  assign wr = req.valid & req.write;
  assign be_mask = lane_mask(req.byte_en);
  assign wr_cmd = wr & hit(req.addr, pcfg_pkg::OFF_COMMAND_STATUS);
  assign wr_power = wr & hit(req.addr, pcfg_pkg::OFF_POWER_CTRL);
  assign pme_clear = wr_power & req.byte_en[1] & req.wdata[pcfg_pkg::BIT_PME_STATUS];
  // Whole-word merge; only bits 14:0 are taken, bit 15 has its own clear
  assign power_merged = merge(power_ctrl_q, req.wdata, req.byte_en,
                              pcfg_pkg::POWER_CTRL_RW_MASK);

  // ------------------------------------------------------------
  // Software reset
  // ------------------------------------------------------------
  // Deliberately unread: the controller's soft reset must not disturb
  // this bank, so the driver scratch and base addresses survive it

  // Capability strap from another part of the controller, synchronised
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      cap_sync1_q <= 1'b0;
      cap_sync2_q <= 1'b0;
    end
    else
    begin
      cap_sync1_q <= capability_offered;
      cap_sync2_q <= cap_sync1_q;
    end
  end

  // ------------------------------------------------------------
  // Serial-memory identity values
  // ------------------------------------------------------------
  // Captured on the loader's valid strobe after reset release; no host write path
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ident_q <= '0;
    else if (eeprom_valid)
      ident_q <= eeprom_data;
  end

  // ------------------------------------------------------------
  // Command word
  // ------------------------------------------------------------
  localparam logic [31:0] COMMAND_RW_MASK =
    (32'h1 << pcfg_pkg::BIT_SYSTEM_ERROR_RESPONSE) | (32'h1 << pcfg_pkg::BIT_PARITY_RESPONSE) |
    (32'h1 << pcfg_pkg::BIT_BUS_MASTER) | (32'h1 << pcfg_pkg::BIT_MEMORY_SPACE) |
    (32'h1 << pcfg_pkg::BIT_IO_SPACE);

  // Soft reset deliberately not in the sensitivity of any register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      command_q <= '0;
    else if (wr_cmd)
      command_q <= merge(command_q, req.wdata, req.byte_en, COMMAND_RW_MASK);
  end

  // ------------------------------------------------------------
  // Error status: set wins over write-one-to-clear
  // ------------------------------------------------------------
  assign system_error_d = events.address_parity_error &
                          command_q[pcfg_pkg::BIT_SYSTEM_ERROR_RESPONSE];

  always_comb
  begin
    stat_wr_clear = '0;
    if (wr_cmd)
      stat_wr_clear = req.wdata & be_mask & pcfg_pkg::STATUS_CLEAR_MASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      status_q <= '0;
    else
    begin
      status_q[pcfg_pkg::BIT_PARITY_ERROR_SEEN] <= events.parity_error | events.address_parity_error |
        (status_q[pcfg_pkg::BIT_PARITY_ERROR_SEEN] &
         ~stat_wr_clear[pcfg_pkg::BIT_PARITY_ERROR_SEEN]);
      status_q[pcfg_pkg::BIT_SYSTEM_ERROR_SIGNALLED] <= system_error_d |
        (status_q[pcfg_pkg::BIT_SYSTEM_ERROR_SIGNALLED] &
         ~stat_wr_clear[pcfg_pkg::BIT_SYSTEM_ERROR_SIGNALLED]);
      status_q[pcfg_pkg::BIT_MASTER_ABORT_SEEN] <= events.master_abort |
        (status_q[pcfg_pkg::BIT_MASTER_ABORT_SEEN] &
         ~stat_wr_clear[pcfg_pkg::BIT_MASTER_ABORT_SEEN]);
      status_q[pcfg_pkg::BIT_TARGET_ABORT_SEEN] <= events.target_abort |
        (status_q[pcfg_pkg::BIT_TARGET_ABORT_SEEN] &
         ~stat_wr_clear[pcfg_pkg::BIT_TARGET_ABORT_SEEN]);
      status_q[pcfg_pkg::BIT_DATA_PARITY_REPORTED] <=
        (events.perr_involved & events.acting_master &
         command_q[pcfg_pkg::BIT_PARITY_RESPONSE]) |
        (status_q[pcfg_pkg::BIT_DATA_PARITY_REPORTED] &
         ~stat_wr_clear[pcfg_pkg::BIT_DATA_PARITY_REPORTED]);
    end
  end

  // System error pin request and controller status flag
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      serr_assert <= 1'b0;
      system_error_status <= 1'b0;
    end
    else
    begin
      serr_assert <= system_error_d;
      // Flag pulses; parity errors are ignored while response is off
      system_error_status <= (events.parity_error | events.address_parity_error) &
                             command_q[pcfg_pkg::BIT_PARITY_RESPONSE];
    end
  end

  // ------------------------------------------------------------
  // Plain read/write registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      latency_q <= '0;
      line_size_q <= '0;
      io_base_q <= pcfg_pkg::IO_BASE_RESET;
      memory_base_q <= '0;
      boot_rom_q <= '0;
      int_line_q <= '0;
      scratch_q <= '0;
    end
    else if (wr)
    begin
      if (hit(req.addr, pcfg_pkg::OFF_LATENCY_LINE))
      begin
        if (req.byte_en[1])
          latency_q <= req.wdata[15:8];
        if (req.byte_en[0])
          line_size_q <= req.wdata[7:0];
      end
      if (hit(req.addr, pcfg_pkg::OFF_IO_BASE))
        io_base_q <= merge(io_base_q, req.wdata, req.byte_en, pcfg_pkg::IO_BASE_MASK);
      if (hit(req.addr, pcfg_pkg::OFF_MEMORY_BASE))
        memory_base_q <= merge(memory_base_q, req.wdata, req.byte_en, pcfg_pkg::MEMORY_BASE_MASK);
      if (hit(req.addr, pcfg_pkg::OFF_BOOT_ROM_BASE))
        boot_rom_q <= merge(boot_rom_q, req.wdata, req.byte_en, pcfg_pkg::BOOT_ROM_MASK);
      if (hit(req.addr, pcfg_pkg::OFF_INTERRUPT_TIMING) && req.byte_en[0])
        int_line_q <= req.wdata[7:0];
      if (hit(req.addr, pcfg_pkg::OFF_DRIVER_SCRATCH))
        scratch_q <= merge(scratch_q, req.wdata, req.byte_en, pcfg_pkg::SCRATCH_MASK);
    end
  end

  // Power control: data select and enable writable, event status write-one-to-clear
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      power_ctrl_q <= '0;
    else
    begin
      if (wr_power)
        power_ctrl_q[14:0] <= power_merged[14:0];
      // Set wins over a clear in the same cycle
      power_ctrl_q[pcfg_pkg::BIT_PME_STATUS] <= events.pme_event |
        (power_ctrl_q[pcfg_pkg::BIT_PME_STATUS] & ~pme_clear);
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Unmapped words and reserved bits fall through to zero
  always_comb
  begin
    rdata_d = '0;
    case (req.addr[7:2])
      pcfg_pkg::OFF_LOADED_IDENTITY[7:2]:
        rdata_d = {ident_q.loaded_device_code, ident_q.loaded_maker_code};
      pcfg_pkg::OFF_COMMAND_STATUS[7:2]:
      begin
        rdata_d = status_q | command_q;
        rdata_d[pcfg_pkg::BIT_SELECT_TIMING_HI:pcfg_pkg::BIT_SELECT_TIMING_LO] =
          pcfg_pkg::SELECT_TIMING_MEDIUM;
        rdata_d[pcfg_pkg::BIT_BACK_TO_BACK_CAPABLE] = 1'b1;
        rdata_d[pcfg_pkg::BIT_NEW_CAPABILITIES] = cap_sync2_q;
      end
      pcfg_pkg::OFF_CLASS_REVISION[7:2]:
        rdata_d = pcfg_pkg::CLASS_REVISION_VALUE;
      pcfg_pkg::OFF_LATENCY_LINE[7:2]:
        rdata_d = {16'h0000, latency_q, line_size_q};
      pcfg_pkg::OFF_IO_BASE[7:2]:
        rdata_d = io_base_q;
      pcfg_pkg::OFF_MEMORY_BASE[7:2]:
        rdata_d = memory_base_q;
      pcfg_pkg::OFF_CARD_INFO[7:2]:
        rdata_d = ident_q.card_info;
      pcfg_pkg::OFF_SUBSYSTEM_ID[7:2]:
        rdata_d = {ident_q.subsystem_device, ident_q.subsystem_maker};
      pcfg_pkg::OFF_BOOT_ROM_BASE[7:2]:
        rdata_d = boot_rom_q;
      pcfg_pkg::OFF_CAPABILITY_PTR[7:2]:
        rdata_d = {24'h000000, pcfg_pkg::CAPABILITY_PTR_VALUE};
      pcfg_pkg::OFF_INTERRUPT_TIMING[7:2]:
        rdata_d = {ident_q.max_latency, ident_q.min_grant, pcfg_pkg::INTERRUPT_PIN_VALUE,
                   int_line_q};
      pcfg_pkg::OFF_DRIVER_SCRATCH[7:2]:
        rdata_d = scratch_q & pcfg_pkg::SCRATCH_MASK;
      pcfg_pkg::OFF_SIGNATURE[7:2]:
        rdata_d = pcfg_pkg::SIGNATURE_VALUE;
      pcfg_pkg::OFF_POWER_CAP[7:2]:
        rdata_d = pcfg_pkg::POWER_CAP_VALUE;
      pcfg_pkg::OFF_POWER_CTRL[7:2]:
        rdata_d = {16'h0000, power_ctrl_q[15:0]};
      default:
        rdata_d = '0;
    endcase
  end

  // Only enabled byte lanes returned; disabled lanes read as zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rdata <= '0;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.valid & ~req.write;
      if (req.valid && !req.write)
        rdata <= rdata_d & be_mask;
    end
  end

  // ------------------------------------------------------------
  // Control outputs, registered
  // ------------------------------------------------------------
  // One cycle behind the command word; consumers see a clean level
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ctrl <= '0;
    else
    begin
      ctrl.bus_master_enable <= command_q[pcfg_pkg::BIT_BUS_MASTER];
      ctrl.memory_space_enable <= command_q[pcfg_pkg::BIT_MEMORY_SPACE];
      ctrl.io_space_enable <= command_q[pcfg_pkg::BIT_IO_SPACE];
      ctrl.parity_response_enable <= command_q[pcfg_pkg::BIT_PARITY_RESPONSE];
      ctrl.system_error_response_enable <= command_q[pcfg_pkg::BIT_SYSTEM_ERROR_RESPONSE];
      // Boot ROM only decodes with memory space also enabled
      ctrl.boot_rom_enable <= boot_rom_q[0] & command_q[pcfg_pkg::BIT_MEMORY_SPACE];
    end
  end

endmodule
